// *** design/iin_limit_status.sv ***
// Input overcurrent limits, summary status and alert outputs of the controller.
// What this block does
// - Limits are 16 bits: 5-bit signed exponent 15:11, 11-bit signed mantissa.
// - Input overcurrent fault latches output off; response reads fixed C0h.
// - Fault sets other, input, fault flag; raises alert and fault outputs.
// - Warning limit resets to 0019h; crossing sets flags and alert only.
// - Status byte and status word low byte are one storage, reset zero.
// - Alert is asserted while any fault or warning sits in status byte.
// - Status word read returns two-byte summary; alert rule follows status byte.
// - Busy bit 7 of the status byte always reads zero.
// - Bit 6 is one whenever the output is not powered or is latched off.
// - Bit 5 latches an output overvoltage fault until cleared.
// - Bit 4 latches an output overcurrent fault.
// - Bit 3 latches input voltage below the lockout threshold.
// - Bit 2 latches an over-temperature fault or warning.
// - Bit 1 latches any communication, memory or logic fault.
// - Bit 0 latches input overcurrent fault or warning, output undervoltage fault and overcurrent warning.
// - Word bit 13 latches any input voltage or current fault or warning.
`timescale 1ns/100ps
module iin_limit_status
	import pmbus_status_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h58,
	parameter int         IIN_W    = 16
) (
	input  wire logic             clk,                 // 20 MHz clock
	input  wire logic             rstn,                // Async reset, low
	input  wire logic             scl_in,              // Bus clock pin
	input  wire logic             sda_in,              // Bus data pin in
	input  wire logic [IIN_W-1:0] iin_amps,            // Input current, A
	input  wire fault_evt_t       evt_in,              // Datapath events
	input  wire logic             power_delivering,    // Output powered
	input  wire logic             pgood_low,           // Ready pin is low
	output logic                  sda_out,             // Bus data pin out
	output logic                  sda_oe,              // Bus data drive
	output logic                  bus_alert_out,       // Alert, high
	output logic                  regulator_fault_out, // Fault, high
	output logic                  output_disable_out,  // Output latched off
	output logic [1:0]            iin_status_out       // {fault, warning}
);

	ctl_state_t  s;
	ctl_state_t  n;
	link_evt_t   link;
	logic        clr;
	logic        cml_evt;
	logic        fault_hit;
	logic        warn_hit;
	logic [7:0]  sbyte;
	logic [15:0] sword;
	logic [15:0] rdval;
	logic [7:0]  tx_byte;

	serial_bit_engine u_bits (
		.clk     (clk),
		.rstn    (rstn),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.ack_en  (s.ack_en),
		.tx_en   (s.tx_en),
		.tx_byte (tx_byte),
		.evt     (link),
		.sda_oe  (sda_oe)
	);

	// Decodes a linear limit and tests the measurement above it.
	function automatic logic above_limit(
		input logic [IIN_W-1:0] meas,
		input logic [15:0]      lim
	);
		logic signed [47:0] v;
		logic signed [47:0] m;
		logic        [4:0]  e;
		e = lim[EXP_MSB:EXP_LSB];
		v = {{37{lim[MANT_MSB]}}, lim[MANT_MSB:0]};
		if (e[4]) begin
			v = v >>> (~e + 5'h01);
		end else begin
			v = v <<< e;
		end
		m = {{(48-IIN_W){1'b0}}, meas};
		return m > v;
	endfunction

	// A set in the same cycle as a clear wins.
	function automatic logic sticky(input logic cur, clr_i, set_i);
		return (cur & ~clr_i) | set_i;
	endfunction

	function automatic logic readable(input logic [7:0] c);
		return c == CMD_IIN_FAULT_THR || c == CMD_IIN_FAULT_ACT ||
			c == CMD_IIN_WARN_THR || c == CMD_STATUS_BYTE ||
			c == CMD_STATUS_WORD;
	endfunction

	always_comb begin
		sbyte = '0;
		sbyte[SB_BUSY] = 1'b0;
		sbyte[SB_OFF] = ~power_delivering | s.out_dis;
		sbyte[SB_VOUT_OV] = s.fl.vout_ov;
		sbyte[SB_IOUT_OC] = s.fl.iout_oc;
		sbyte[SB_VIN_UV] = s.fl.vin_uv;
		sbyte[SB_TEMP] = s.fl.temp;
		sbyte[SB_CML] = s.fl.cml;
		sbyte[SB_OTHER] = s.fl.other;
		sword = {8'h00, sbyte};
		sword[SW_VOUT] = s.fl.vout;
		sword[SW_IOUT] = s.fl.iout;
		sword[SW_INPUT] = s.fl.input_any;
		sword[SW_MFR] = s.fl.mfr;
		sword[SW_PGOOD] = pgood_low;
	end

	always_comb begin
		case (s.cmd)
			CMD_IIN_FAULT_THR: rdval = s.fault_thr;
			CMD_IIN_FAULT_ACT: rdval = {8'h00, FAULT_ACT_VAL};
			CMD_IIN_WARN_THR:  rdval = s.warn_thr;
			CMD_STATUS_BYTE:   rdval = {8'h00, sword[7:0]};
			CMD_STATUS_WORD:   rdval = sword;
			default:           rdval = 16'h0000;
		endcase
		tx_byte = s.rd_hi ? rdval[15:8] : rdval[7:0];
	end

	always_comb begin
		n = s;
		clr = 1'b0;
		cml_evt = 1'b0;
		fault_hit = above_limit(iin_amps, s.fault_thr);
		warn_hit = above_limit(iin_amps, s.warn_thr);
		if (link.start) begin
			n.ps = P_ADDR;
			n.ack_en = 1'b0;
			n.tx_en = 1'b0;
			n.rd_hi = 1'b0;
		end else if (link.stop) begin
			if (s.ps == P_WDATA) begin
				case (s.cmd)
					CMD_CLEAR_FAULTS: begin
						clr = s.wcnt == 2'h0;
						cml_evt = s.wcnt != 2'h0;
					end
					CMD_IIN_FAULT_THR: begin
						if (s.wcnt == 2'h2) begin
							n.fault_thr = {s.hi, s.lo};
						end else begin
							cml_evt = 1'b1;
						end
					end
					CMD_IIN_WARN_THR: begin
						if (s.wcnt == 2'h2) begin
							n.warn_thr = {s.hi, s.lo};
						end else begin
							cml_evt = 1'b1;
						end
					end
					// The fault response and status are read-only.
					default: cml_evt = 1'b1;
				endcase
			end
			n.ps = P_IDLE;
			n.ack_en = 1'b0;
			n.tx_en = 1'b0;
		end else if (link.byte_v) begin
			case (s.ps)
				P_ADDR: begin
					if (link.data[7:1] == DEV_ADDR) begin
						n.ack_en = 1'b1;
						if (link.data[0]) begin
							n.ps = P_READ;
							n.tx_en = 1'b1;
							n.wcnt = 2'h0;
							cml_evt = ~readable(s.cmd);
						end else begin
							n.ps = P_CMD;
						end
					end else begin
						n.ps = P_IGNORE;
					end
				end
				P_CMD: begin
					n.cmd = link.data;
					n.wcnt = 2'h0;
					n.ps = P_WDATA;
				end
				P_WDATA: begin
					if (s.wcnt == 2'h0) begin
						n.lo = link.data;
					end else if (s.wcnt == 2'h1) begin
						n.hi = link.data;
					end
					if (s.wcnt != 2'h3) begin
						n.wcnt = s.wcnt + 2'h1;
					end
				end
				default: begin
				end
			endcase
		end else if (link.ack_v && s.ps == P_READ) begin
			// The first ack slot of a read is our own address ack.
			if (s.wcnt == 2'h0) begin
				n.wcnt = 2'h1;
			end else if (link.nack) begin
				n.tx_en = 1'b0;
			end else begin
				n.rd_hi = 1'b1;
			end
		end
		n.fl.iin_oc_fault = sticky(s.fl.iin_oc_fault, clr, fault_hit);
		n.fl.iin_oc_warn = sticky(s.fl.iin_oc_warn, clr, warn_hit);
		n.fl.vout_ov = sticky(s.fl.vout_ov, clr, evt_in.ovp);
		n.fl.iout_oc = sticky(s.fl.iout_oc, clr, evt_in.ocp);
		n.fl.vin_uv = sticky(s.fl.vin_uv, clr, evt_in.uvlo);
		n.fl.temp = sticky(s.fl.temp, clr,
			evt_in.ot_fault | evt_in.ot_warn);
		n.fl.cml = sticky(s.fl.cml, clr, evt_in.cml | cml_evt);
		n.fl.other = sticky(s.fl.other, clr, fault_hit | warn_hit |
			evt_in.output_undervoltage_fault |
			evt_in.overcurrent_warning);
		n.fl.input_any = sticky(s.fl.input_any, clr,
			fault_hit | warn_hit | evt_in.uvlo);
		n.fl.vout = sticky(s.fl.vout, clr,
			evt_in.ovp | evt_in.output_undervoltage_fault);
		n.fl.iout = sticky(s.fl.iout, clr,
			evt_in.ocp | evt_in.overcurrent_warning);
		n.fl.mfr = sticky(s.fl.mfr, clr, evt_in.mfr);
		// Latched off with no retry until faults are cleared.
		n.out_dis = sticky(s.out_dis, clr, fault_hit);
		n.alert = n.fl.vout_ov | n.fl.iout_oc | n.fl.vin_uv |
			n.fl.temp | n.fl.cml | n.fl.other;
		n.vrf = n.fl.iin_oc_fault;
		n.sda_lo = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.fault_thr <= FAULT_THR_RST;
			s.warn_thr <= WARN_THR_RST;
		end else begin
			s <= n;
		end
	end

	assign sda_out = s.sda_lo;
	assign bus_alert_out = s.alert;
	assign regulator_fault_out = s.vrf;
	assign output_disable_out = s.out_dis;
	assign iin_status_out = {s.fl.iin_oc_fault, s.fl.iin_oc_warn};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_fault_thr_write;
		link.stop && s.ps == P_WDATA && s.cmd == CMD_IIN_FAULT_THR &&
			s.wcnt == 2'h2;
	endsequence

	sequence s_act_write;
		link.stop && s.ps == P_WDATA && s.cmd == CMD_IIN_FAULT_ACT;
	endsequence

	sequence s_quiet_clear;
		link.stop && s.ps == P_WDATA && s.cmd == CMD_CLEAR_FAULTS &&
			s.wcnt == 2'h0 && !fault_hit && !warn_hit &&
			evt_in == '0;
	endsequence

	AST_THR_WRITE: assert property (
		s_fault_thr_write |=> s.fault_thr == {$past(s.hi), $past(s.lo)})
		else $error("fault limit not written from bus bytes");

	AST_ACT_READ_ONLY: assert property (
		s_act_write |=> s.fl.cml && rdval[7:0] == 8'hc0)
		else $error("fault response write not refused");

	AST_LATCHED_OFF: assert property (
		(output_disable_out && !clr) |=> output_disable_out)
		else $error("output re-enabled without clear");

	AST_FAULT_ACTIONS: assert property (
		fault_hit |=> regulator_fault_out && bus_alert_out &&
			s.fl.other && s.fl.input_any && iin_status_out[1] &&
			output_disable_out)
		else $error("input overcurrent fault actions missing");

	AST_WARN_ACTIONS: assert property (
		(warn_hit && !fault_hit && !s.fl.iin_oc_fault) |=>
			bus_alert_out && s.fl.other && s.fl.input_any &&
			iin_status_out[0] && !regulator_fault_out)
		else $error("input overcurrent warning actions wrong");

	AST_BYTE_IS_WORD: assert property (
		(s.ps == P_READ && s.cmd == CMD_STATUS_BYTE && !s.rd_hi) |->
			tx_byte == sword[7:0])
		else $error("status byte differs from word low byte");

	AST_ALERT_FOLLOWS: assert property (
		(|sbyte[SB_VOUT_OV:SB_OTHER]) |-> bus_alert_out)
		else $error("alert low while status byte holds a fault");

	AST_OFF_RAW: assert property (
		!power_delivering |-> sbyte[SB_OFF] && !sbyte[SB_BUSY])
		else $error("off bit clear while output unpowered");

	AST_OV_LATCH: assert property (
		evt_in.ovp |=> s.fl.vout_ov && s.fl.vout && bus_alert_out)
		else $error("overvoltage not latched");

	AST_CLEAR: assert property (
		s_quiet_clear |=> s.fl == '0 && !bus_alert_out &&
			!output_disable_out)
		else $error("clear faults left a flag set");

	AST_DECODE: assert property (
		(s.warn_thr[EXP_MSB:EXP_LSB] == 5'h00 && !s.warn_thr[MANT_MSB] &&
			{{(IIN_W > 11 ? IIN_W - 11 : 1){1'b0}},
			s.warn_thr[MANT_MSB:0]} < iin_amps) |=> s.fl.iin_oc_warn)
		else $error("warning compare wrong for zero exponent");

	AST_OC_LATCH: assert property (
		evt_in.ocp |=> s.fl.iout_oc && s.fl.iout && bus_alert_out)
		else $error("output overcurrent not latched");

	AST_UV_LATCH: assert property (
		evt_in.uvlo |=> s.fl.vin_uv && s.fl.input_any && bus_alert_out)
		else $error("input undervoltage not latched");

	AST_TEMP_LATCH: assert property (
		(evt_in.ot_fault || evt_in.ot_warn) |=> s.fl.temp && bus_alert_out)
		else $error("over-temperature not latched");

	AST_CML_LATCH: assert property (
		(evt_in.cml || cml_evt) |=> s.fl.cml && bus_alert_out)
		else $error("communication fault not latched");

	AST_OTHER_LATCH: assert property (
		(evt_in.output_undervoltage_fault || evt_in.overcurrent_warning)
			|=> s.fl.other && bus_alert_out)
		else $error("other fault not latched");

	AST_READ_LOW_FIRST: assert property (
		(s.ps == P_READ && s.wcnt == 2'h0) |-> !s.rd_hi)
		else $error("read would start with the high byte");

endmodule // iin_limit_status

// *** design/pmbus_status_pkg.sv ***
// Shared constants and types for the input current limit and status block.
package pmbus_status_pkg;

	// Command codes seen on the management bus.
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_IIN_FAULT_THR = 8'h5b;
	localparam logic [7:0] CMD_IIN_FAULT_ACT = 8'h5c;
	localparam logic [7:0] CMD_IIN_WARN_THR  = 8'h5d;
	localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;

	// Values after reset and the fixed fault response.
	localparam logic [15:0] FAULT_THR_RST = 16'h00ff;
	localparam logic [15:0] WARN_THR_RST  = 16'h0019;
	localparam logic [7:0]  FAULT_ACT_VAL = 8'hc0;

	// Linear format field positions.
	localparam int EXP_MSB  = 15;
	localparam int EXP_LSB  = 11;
	localparam int MANT_MSB = 10;

	// Summary byte and word bit positions.
	localparam int SB_BUSY    = 7;
	localparam int SB_OFF     = 6;
	localparam int SB_VOUT_OV = 5;
	localparam int SB_IOUT_OC = 4;
	localparam int SB_VIN_UV  = 3;
	localparam int SB_TEMP    = 2;
	localparam int SB_CML     = 1;
	localparam int SB_OTHER   = 0;
	localparam int SW_VOUT    = 15;
	localparam int SW_IOUT    = 14;
	localparam int SW_INPUT   = 13;
	localparam int SW_MFR     = 12;
	localparam int SW_PGOOD   = 11;

	// Serial bit counts per byte.
	localparam logic [3:0] LAST_BIT  = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Fault and warning events from the converter datapath.
	typedef struct packed {
		logic ovp;
		logic ocp;
		logic uvlo;
		logic ot_fault;
		logic ot_warn;
		logic cml;
		logic output_undervoltage_fault;
		logic overcurrent_warning;
		logic mfr;
	} fault_evt_t;

	typedef struct packed {
		logic vout;
		logic iout;
		logic input_any;
		logic mfr;
		logic vout_ov;
		logic iout_oc;
		logic vin_uv;
		logic temp;
		logic cml;
		logic other;
		logic iin_oc_fault;
		logic iin_oc_warn;
	} status_flags_t;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       byte_v;
		logic       ack_v;
		logic       nack;
		logic [7:0] data;
	} link_evt_t;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_d;
		logic       sda_d;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       ackph;
		logic       txing;
		logic       oe;
		link_evt_t  ev;
	} link_state_t;

	typedef enum logic [2:0] {
		P_IDLE, P_ADDR, P_CMD, P_WDATA, P_READ, P_IGNORE
	} proto_t;

	typedef struct packed {
		proto_t        ps;
		logic [7:0]    cmd;
		logic [7:0]    lo;
		logic [7:0]    hi;
		logic [1:0]    wcnt;
		logic          rd_hi;
		logic          ack_en;
		logic          tx_en;
		logic [15:0]   fault_thr;
		logic [15:0]   warn_thr;
		status_flags_t fl;
		logic          out_dis;
		logic          alert;
		logic          vrf;
		logic          sda_lo;
	} ctl_state_t;

endpackage

// *** design/serial_bit_engine.sv ***
// Bit level engine of the management bus: start, stop, bytes and ack slots.
`timescale 1ns/100ps
module serial_bit_engine
	import pmbus_status_pkg::*;
(
	input  wire logic       clk,     // System clock
	input  wire logic       rstn,    // Asynchronous reset, active low
	input  wire logic       scl_in,  // Bus clock pin level
	input  wire logic       sda_in,  // Bus data pin level
	input  wire logic       ack_en,  // Acknowledge the byte being received
	input  wire logic       tx_en,   // Send a byte after this ack slot
	input  wire logic [7:0] tx_byte, // Byte to send, most significant first
	output link_evt_t       evt,     // Bus events, one-cycle pulses
	output logic            sda_oe   // High while the data line is pulled low
);

	link_state_t s;
	link_state_t n;
	logic        scl;
	logic        sda;

	assign scl = s.scl_s[1];
	assign sda = s.sda_s[1];
	assign evt = s.ev;
	assign sda_oe = s.oe;

	always_comb begin
		n = s;
		n.scl_s = {s.scl_s[0], scl_in};
		n.sda_s = {s.sda_s[0], sda_in};
		n.scl_d = scl;
		n.sda_d = sda;
		n.ev.start = 1'b0;
		n.ev.stop = 1'b0;
		n.ev.byte_v = 1'b0;
		n.ev.ack_v = 1'b0;
		if (scl && s.scl_d && s.sda_d && !sda) begin
			n.cnt = '0;
			n.ackph = 1'b0;
			n.txing = 1'b0;
			n.oe = 1'b0;
			n.ev.start = 1'b1;
		end else if (scl && s.scl_d && !s.sda_d && sda) begin
			n.cnt = '0;
			n.ackph = 1'b0;
			n.txing = 1'b0;
			n.oe = 1'b0;
			n.ev.stop = 1'b1;
		end else if (scl && !s.scl_d) begin
			if (s.ackph) begin
				n.ev.ack_v = 1'b1;
				n.ev.nack = sda;
			end else begin
				n.cnt = s.cnt + 4'h1;
				if (!s.txing) begin
					n.sh = {s.sh[6:0], sda};
				end
				if (s.cnt == LAST_BIT) begin
					n.ev.byte_v = 1'b1;
					n.ev.data = {s.sh[6:0], sda};
				end
			end
		end else if (!scl && s.scl_d) begin
			if (s.ackph) begin
				// The ack slot ends; the next byte starts on this edge.
				n.ackph = 1'b0;
				n.cnt = '0;
				n.txing = tx_en;
				n.sh = tx_byte;
				n.oe = tx_en & ~tx_byte[7];
			end else if (s.cnt == BYTE_BITS) begin
				n.ackph = 1'b1;
				n.oe = ack_en & ~s.txing;
			end else if (s.txing) begin
				n.sh = {s.sh[6:0], 1'b0};
				n.oe = ~s.sh[6];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule // serial_bit_engine

// *** verif/iin_limit_status_tb.sv ***
// Self-checking bench for the input current limit and status block.
`timescale 1ns/100ps
module iin_limit_status_tb;
	import pmbus_status_pkg::*;

	localparam logic [6:0] ADDR = 7'h58;

	logic        clk;
	logic        rstn;
	logic        scl_low;
	logic        sda_low;
	logic        sda_out;
	logic        sda_oe;
	logic        alert;
	logic        vrf;
	logic        odis;
	logic [1:0]  iin_st;
	logic [15:0] iin;
	fault_evt_t  evt;
	logic        power_on;
	logic        pg_low;
	logic [15:0] rv;
	logic [15:0] outs;
	int          bad_count;
	int          num_checks;
	logic [15:0] warn_set [2] = '{16'h0019, 16'hf833};
	logic [15:0] evt_word [9] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004,
		16'h0004, 16'h0002, 16'h8001, 16'h4001, 16'h1000};
	wire logic   scl = !scl_low;
	wire logic   sda = !(sda_low | sda_oe);

	assign outs = {10'h000, sda_out, alert, vrf, odis, iin_st};

	iin_limit_status dut (
		.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.iin_amps(iin), .evt_in(evt), .power_delivering(power_on),
		.pgood_low(pg_low), .sda_out(sda_out), .sda_oe(sda_oe),
		.bus_alert_out(alert), .regulator_fault_out(vrf),
		.output_disable_out(odis), .iin_status_out(iin_st)
	);

	pmbus_host host (
		.clk(clk), .sda_in(sda), .scl_low(scl_low), .sda_low(sda_low)
	);

	initial begin
		clk = 1'b0;
	end

	always #25 clk = !clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s got %h expected %h",
				$time, what, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] cmd, input int n,
		input logic [15:0] exp, input string what);
		host.rd(ADDR, cmd, n, rv);
		chk(rv, exp, what);
	endtask

	task automatic done(input string name);
		$display("Test %s done", name);
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		bad_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		bad_count  = 0;
		num_checks = 0;
		rstn       = 1'b0;
		iin        = 16'h0000;
		evt        = '0;
		power_on   = 1'b1;
		pg_low     = 1'b0;
		cyc(5);
		rstn = 1'b1;
		cyc(3);
		rdc(CMD_IIN_FAULT_THR, 2, 16'h00ff, "fault limit reset");
		rdc(CMD_IIN_WARN_THR, 2, 16'h0019, "warn limit reset");
		rdc(CMD_IIN_FAULT_ACT, 1, 16'h00c0, "action reset");
		rdc(CMD_STATUS_BYTE, 1, 16'h0000, "byte reset");
		rdc(CMD_STATUS_WORD, 2, 16'h0000, "word reset");
		chk(outs, 16'h0000, "outputs reset");
		done("reset");
		// A zero and a negative exponent both give a 25 A threshold.
		for (int t = 0; t < 2; t++) begin
			host.wr(ADDR, CMD_IIN_WARN_THR, warn_set[t], 2);
			rdc(CMD_IIN_WARN_THR, 2, warn_set[t], "warn limit");
			iin = 16'h0019;
			cyc(4);
			chk(outs, 16'h0000, "at limit");
			iin = 16'h001a;
			cyc(4);
			chk(outs, 16'h0011, "over warn");
			rdc(CMD_STATUS_WORD, 2, 16'h2001, "warn word");
			rdc(CMD_STATUS_BYTE, 1, 16'h0001, "warn byte");
			host.clear(ADDR);
			chk(outs, 16'h0011, "persisting warn");
			iin = 16'h0000;
			host.clear(ADDR);
			rdc(CMD_STATUS_WORD, 2, 16'h0000, "warn cleared");
		end
		done("warning");
		host.wr(ADDR, CMD_IIN_FAULT_THR, 16'h0832, 2);
		iin = 16'h0064;
		cyc(4);
		chk(outs, 16'h0011, "at fault limit");
		iin = 16'h0065;
		cyc(4);
		chk(outs, 16'h001f, "fault outputs");
		iin = 16'h0000;
		cyc(20);
		chk(outs, 16'h001f, "stays off");
		rdc(CMD_STATUS_WORD, 2, 16'h2041, "fault word");
		host.clear(ADDR);
		chk(outs, 16'h0000, "fault cleared");
		done("fault");
		for (int e = 0; e < 9; e++) begin
			evt = fault_evt_t'(9'h100 >> e);
			cyc(1);
			evt = '0;
			cyc(2);
			chk(outs, (e == 8) ? 16'h0000 : 16'h0010, "event alert");
			rdc(CMD_STATUS_WORD, 2, evt_word[e], "event word");
			host.clear(ADDR);
			chk(outs, 16'h0000, "event cleared");
		end
		done("events");
		power_on = 1'b0;
		pg_low   = 1'b1;
		cyc(2);
		rdc(CMD_STATUS_WORD, 2, 16'h0840, "off and ready low");
		power_on = 1'b1;
		pg_low   = 1'b0;
		cyc(2);
		rdc(CMD_STATUS_BYTE, 1, 16'h0000, "off is raw");
		done("raw bits");
		host.wr(ADDR, CMD_STATUS_BYTE, 16'h00ff, 1);
		rdc(CMD_STATUS_BYTE, 1, 16'h0002, "byte read only");
		host.clear(ADDR);
		host.wr(ADDR, CMD_IIN_FAULT_ACT, 16'h0000, 1);
		rdc(CMD_IIN_FAULT_ACT, 1, 16'h00c0, "action fixed");
		rdc(CMD_STATUS_WORD, 2, 16'h0002, "action refused");
		host.clear(ADDR);
		host.wr(ADDR, CMD_IIN_FAULT_THR, 16'h1234, 3);
		rdc(CMD_IIN_FAULT_THR, 2, 16'h0832, "three bytes");
		host.clear(ADDR);
		host.wr(7'h33, CMD_IIN_FAULT_THR, 16'h1234, 2);
		chk({15'h0000, host.addr_ack}, 16'h0000, "other address ack");
		rdc(CMD_IIN_FAULT_THR, 2, 16'h0832, "other address");
		rdc(CMD_STATUS_WORD, 2, 16'h0000, "no error logged");
		done("refusals");
		report_and_stop();
	end
endmodule // iin_limit_status_tb

// *** verif/pmbus_host.sv ***
// Behavioural management bus host driving clock and data as open drain.
`timescale 1ns/100ps
module pmbus_host
	import pmbus_status_pkg::*;
(
	input  wire logic clk,     // System clock used for pacing
	input  wire logic sda_in,  // Resolved data line level
	output logic      scl_low, // Pull the clock line low
	output logic      sda_low  // Pull the data line low
);
	logic addr_ack; // Address byte of the last transfer was acknowledged

	initial begin
		scl_low  = 1'b0;
		sda_low  = 1'b0;
		addr_ack = 1'b0;
	end

	// Nine cycles a half bit keeps each clock phase above eight cycles.
	task automatic half();
		repeat (9) @(posedge clk);
		#1;
	endtask

	task automatic start();
		sda_low = 1'b0;
		half();
		scl_low = 1'b0;
		half();
		sda_low = 1'b1;
		half();
		scl_low = 1'b1;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		half();
		scl_low = 1'b0;
		half();
		sda_low = 1'b0;
		half();
	endtask

	// Data moves two cycles after the clock falls, except the first bit after a start, which moves with the fall.
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		half();
		scl_low = 1'b0;
		half();
		r = sda_in;
		scl_low = 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic byte_io(input logic [7:0] b, input logic last,
		output logic [7:0] r, output logic acked);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
		bit_io(last, a);
		acked = !a;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
		input logic [15:0] d, input int n);
		logic [7:0] r;
		logic       k;
		start();
		byte_io({a, 1'b0}, 1'b1, r, addr_ack);
		byte_io(cmd, 1'b1, r, k);
		for (int i = 0; i < n; i++) byte_io(d[8*(i%2) +: 8], 1'b1, r, k);
		stop();
	endtask

	task automatic clear(input logic [6:0] a);
		wr(a, CMD_CLEAR_FAULTS, 16'h0000, 0);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
		input int n, output logic [15:0] d);
		logic [7:0] r;
		logic       k;
		d = 16'h0000;
		start();
		byte_io({a, 1'b0}, 1'b1, r, addr_ack);
		byte_io(cmd, 1'b1, r, k);
		start();
		byte_io({a, 1'b1}, 1'b1, r, k);
		for (int i = 0; i < n; i++) begin
			byte_io(8'hff, i == n - 1, r, k);
			d[8*i +: 8] = r;
		end
		stop();
	endtask
endmodule // pmbus_host
